//--- hdl/dram_cfg_pkg.sv
// Constants and types shared by the DRAM row type and refresh control logic.
//
// Behaviour
// - While the PCI-to-DRAM pipeline bit is clear (default) write pipelining is restricted.
// - When the write-combine bit is set sequential CPU-to-PCI writes may merge into one burst.
// - While read-around-write is clear (default) posted writes retire before any read.
// - RAS precharge is four host clocks when the precharge bit is 1, else three.
// - The 16-bit row type register holds a 2-bit type per row, row n at bits 2n+1:2n.
// - A row type pair decodes 00 FPM, 01 EDO, 10 burst EDO, 11 empty.
// - Cycle timing is chosen from the target row's type before a DRAM cycle starts.
// - With the queue bit set refreshes queue four deep and the fourth becomes priority.
// - With the queue bit clear every refresh request is a priority request.
// - The EDO detect bit turns on a special timing mode for per-row EDO detection.
// - Refresh type bit 1 selects RAS-only refresh, 0 selects CAS-before-RAS.
// - Refresh rate 000 disables refresh, 001 is normal, 111 is fast, others reserved.
// - The normal refresh interval follows the host frequency selection.
// - A write that changes the refresh rate restarts the refresh timer.
// - Fast refresh requests one refresh every 32 host clocks.
`default_nettype none

package dram_cfg_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_BRIDGE_CFG  = 10'h050;
    localparam logic [9:0] IDX_BUFFER_CTRL = 10'h053;
    localparam logic [9:0] IDX_AUX_CTRL    = 10'h054;
    localparam logic [9:0] IDX_ROW_TYPE    = 10'h055;
    localparam logic [9:0] IDX_ROW_TYPE_HI = 10'h056;
    localparam logic [9:0] IDX_DRAM_CTRL   = 10'h057;

    // Reset values.
    localparam logic [7:0]  RST_BRIDGE_CFG  = 8'h01;
    localparam logic [7:0]  RST_BUFFER_CTRL = 8'h00;
    localparam logic [7:0]  RST_AUX_CTRL    = 8'h00;
    localparam logic [15:0] RST_ROW_TYPE    = 16'h0000;
    localparam logic [7:0]  RST_DRAM_CTRL   = 8'h01;

    // Writable bit masks; reserved bits read as zero.
    localparam logic [7:0] MASK_BRIDGE_CFG  = 8'h03;
    localparam logic [7:0] MASK_BUFFER_CTRL = 8'h07;
    localparam logic [7:0] MASK_AUX_CTRL    = 8'h82;
    localparam logic [7:0] MASK_DRAM_CTRL   = 8'h77;

    // Field positions.
    localparam int BIT_PIPELINE_EN   = 2;
    localparam int BIT_COMBINE_EN    = 1;
    localparam int BIT_RAW_EN        = 0;
    localparam int BIT_PRECHARGE     = 7;
    localparam int BIT_LOW_ADDR      = 1;
    localparam int BIT_QUEUE_EN      = 6;
    localparam int BIT_EDO_DETECT    = 5;
    localparam int BIT_REFRESH_TYPE  = 4;
    localparam int RATE_LSB          = 0;
    localparam int RATE_W            = 3;
    localparam int HFS_LSB           = 0;
    localparam int HFS_W             = 2;

    // Refresh rate codes.
    localparam logic [2:0] RATE_OFF    = 3'b000;
    localparam logic [2:0] RATE_NORMAL = 3'b001;
    localparam logic [2:0] RATE_FAST   = 3'b111;

    // Host frequency selection codes.
    localparam logic [1:0] HFS_60 = 2'b01;
    localparam logic [1:0] HFS_66 = 2'b10;

    // Precharge lengths in host clocks.
    localparam logic [2:0] PRECHARGE_SHORT = 3'd3;
    localparam logic [2:0] PRECHARGE_LONG  = 3'd4;

    // Fast refresh interval in host clocks, row count and refresh queue depth.
    localparam int FAST_REFRESH_CLKS = 32;
    localparam int ROWS              = 8;
    localparam int QUEUE_DEPTH       = 4;

    typedef enum logic [1:0] {
        ROW_FPM   = 2'b00,
        ROW_EDO   = 2'b01,
        ROW_BEDO  = 2'b10,
        ROW_EMPTY = 2'b11
    } row_type_t;

endpackage : dram_cfg_pkg

`default_nettype wire

//--- hdl/dram_row_type_refresh_control.sv
// APB register block for DRAM row types, precharge, buffer options and refresh.
`default_nettype none

module dram_row_type_refresh_control
    import dram_cfg_pkg::*;
#(
    parameter int ADDR_W          = 12,
    parameter int REFRESH_CNT_W   = 12,
    parameter int NORMAL_CLKS_60  = 936,
    parameter int NORMAL_CLKS_66  = 1030
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // DRAM cycle timing lookup.
    input  wire logic              cycle_req,
    input  wire logic [2:0]        cycle_row,
    output logic                   cycle_go,
    output logic [1:0]             cycle_type,
    output logic                   cycle_row_empty,
    output logic [7:0]             row_populated,
    output logic [2:0]             precharge_clks,
    output logic                   edo_detect_mode,
    // Refresh.
    input  wire logic              refresh_done,
    output logic                   refresh_req,
    output logic                   refresh_priority,
    output logic                   refresh_type_sel,
    // Buffer options and drive selection.
    output logic                   pci_dram_pipeline_en,
    output logic                   write_combine_en,
    output logic                   read_around_write_en,
    output logic                   low_addr_drive_sel
);

    //////////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0]  bridge_config_q;
    logic [7:0]  buffer_control_q;
    logic [7:0]  auxiliary_control_q;
    logic [15:0] dram_row_type_q;
    logic [7:0]  dram_control_q;

    logic [9:0]  idx;
    logic        setup;
    logic        wr_commit;
    logic        hit;
    logic [31:0] rd_word;

    // Picks the 2-bit type field of one row.
    function automatic row_type_t row_type_of(input logic [15:0] types, input logic [2:0] row);
        row_type_of = row_type_t'(types[{row, 1'b0} +: 2]);
    endfunction

    function automatic logic is_mapped(input logic [9:0] index);
        is_mapped = (index == IDX_BRIDGE_CFG)  || (index == IDX_BUFFER_CTRL) ||
                    (index == IDX_AUX_CTRL)    || (index == IDX_ROW_TYPE)    ||
                    (index == IDX_ROW_TYPE_HI) || (index == IDX_DRAM_CTRL);
    endfunction

    assign idx       = paddr[11:2];
    assign setup     = psel && !penable;
    assign hit       = is_mapped(idx);
    assign wr_commit = psel && penable && pready && pwrite && !pslverr;

    //////////////////////////////////////////////////////////////////////////////////////
    // APB handshake: one access cycle, answer prepared in the setup cycle.

    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            IDX_BRIDGE_CFG:  rd_word[7:0]  = bridge_config_q;
            IDX_BUFFER_CTRL: rd_word[7:0]  = buffer_control_q;
            IDX_AUX_CTRL:    rd_word[7:0]  = auxiliary_control_q;
            IDX_ROW_TYPE:    rd_word[15:0] = dram_row_type_q;
            IDX_ROW_TYPE_HI: rd_word[7:0]  = dram_row_type_q[15:8];
            IDX_DRAM_CTRL:   rd_word[7:0]  = dram_control_q;
            default:         rd_word       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= (!pwrite && hit) ? rd_word : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Register writes; byte lanes honoured so the row type takes single bytes.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_config_q <= RST_BRIDGE_CFG;
        end else if (wr_commit && idx == IDX_BRIDGE_CFG && pstrb[0]) begin
            bridge_config_q <= pwdata[7:0] & MASK_BRIDGE_CFG;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_control_q <= RST_BUFFER_CTRL;
        end else if (wr_commit && idx == IDX_BUFFER_CTRL && pstrb[0]) begin
            buffer_control_q <= pwdata[7:0] & MASK_BUFFER_CTRL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auxiliary_control_q <= RST_AUX_CTRL;
        end else if (wr_commit && idx == IDX_AUX_CTRL && pstrb[0]) begin
            auxiliary_control_q <= pwdata[7:0] & MASK_AUX_CTRL;
        end
    end

    // Word 0x55 holds both bytes in lanes 0 and 1; word 0x56 holds the upper
    // byte in lane 0, so byte-wise software can reach either half.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_row_type_q <= RST_ROW_TYPE;
        end else if (wr_commit) begin
            if (idx == IDX_ROW_TYPE && pstrb[0]) begin
                dram_row_type_q[7:0] <= pwdata[7:0];
            end
            if (idx == IDX_ROW_TYPE && pstrb[1]) begin
                dram_row_type_q[15:8] <= pwdata[15:8];
            end else if (idx == IDX_ROW_TYPE_HI && pstrb[0]) begin
                dram_row_type_q[15:8] <= pwdata[7:0];
            end
        end
    end

    logic dram_ctrl_wr;
    logic rate_changed;

    assign dram_ctrl_wr = wr_commit && idx == IDX_DRAM_CTRL && pstrb[0];
    assign rate_changed = dram_ctrl_wr &&
        (pwdata[RATE_LSB +: RATE_W] != dram_control_q[RATE_LSB +: RATE_W]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_control_q <= RST_DRAM_CTRL;
        end else if (dram_ctrl_wr) begin
            dram_control_q <= pwdata[7:0] & MASK_DRAM_CTRL;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Configuration outputs, each a register bit except precharge_clks, a registered 3 or 4 chosen by the precharge bit.

    assign pci_dram_pipeline_en = buffer_control_q[BIT_PIPELINE_EN];
    assign write_combine_en     = buffer_control_q[BIT_COMBINE_EN];
    assign read_around_write_en = buffer_control_q[BIT_RAW_EN];
    assign low_addr_drive_sel   = auxiliary_control_q[BIT_LOW_ADDR];
    assign edo_detect_mode      = dram_control_q[BIT_EDO_DETECT];
    assign refresh_type_sel     = dram_control_q[BIT_REFRESH_TYPE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            precharge_clks <= PRECHARGE_SHORT;
        end else begin
            precharge_clks <= auxiliary_control_q[BIT_PRECHARGE] ?
                              PRECHARGE_LONG : PRECHARGE_SHORT;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Row type lookup for each DRAM cycle.

    genvar r;
    generate
        for (r = 0; r < ROWS; r++) begin : g_pop
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    row_populated[r] <= 1'b1;
                end else begin
                    row_populated[r] <= row_type_of(dram_row_type_q, 3'(r)) != ROW_EMPTY;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_go        <= 1'b0;
            cycle_type      <= ROW_FPM;
            cycle_row_empty <= 1'b0;
        end else begin
            cycle_go <= cycle_req;
            if (cycle_req) begin
                cycle_type      <= row_type_of(dram_row_type_q, cycle_row);
                cycle_row_empty <= row_type_of(dram_row_type_q, cycle_row) == ROW_EMPTY;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Refresh scheduling.

    localparam logic [REFRESH_CNT_W-1:0] FAST_INTERVAL = REFRESH_CNT_W'(FAST_REFRESH_CLKS);
    localparam logic [REFRESH_CNT_W-1:0] NORM_60       = REFRESH_CNT_W'(NORMAL_CLKS_60);
    localparam logic [REFRESH_CNT_W-1:0] NORM_66       = REFRESH_CNT_W'(NORMAL_CLKS_66);

    logic [2:0]               rate;
    logic                     refresh_run;
    logic [REFRESH_CNT_W-1:0] interval;
    logic                     refresh_tick;

    assign rate = dram_control_q[RATE_LSB +: RATE_W];

    // Reserved rate codes issue no refresh, the same as disabled.
    always_comb begin
        refresh_run = 1'b0;
        interval    = FAST_INTERVAL;
        case (rate)
            RATE_NORMAL: begin
                refresh_run = 1'b1;
                interval    = (bridge_config_q[HFS_LSB +: HFS_W] == HFS_66) ?
                              NORM_66 : NORM_60;
            end
            RATE_FAST: begin
                refresh_run = 1'b1;
                interval    = FAST_INTERVAL;
            end
            default: refresh_run = 1'b0;
        endcase
    end

    refresh_timer #(
        .CNT_W    (REFRESH_CNT_W)
    ) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (refresh_run),
        .restart  (rate_changed),
        .interval (interval),
        .tick_q   (refresh_tick)
    );

    refresh_queue #(
        .DEPTH      (QUEUE_DEPTH)
    ) u_queue (
        .pclk       (pclk),
        .presetn    (presetn),
        .tick       (refresh_tick),
        .done       (refresh_done),
        .queue_en   (dram_control_q[BIT_QUEUE_EN]),
        .pending_q  (),
        .req_q      (refresh_req),
        .priority_q (refresh_priority)
    );

endmodule // dram_row_type_refresh_control

`default_nettype wire

//--- hdl/refresh_queue.sv
// Pending refresh counter with priority escalation.
`default_nettype none

module refresh_queue #(
    parameter int DEPTH = 4
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       tick,
    input  wire logic                       done,
    input  wire logic                       queue_en,
    output logic [$clog2(DEPTH+1)-1:0]      pending_q,
    output logic                            req_q,
    output logic                            priority_q
);

    localparam int PW = $clog2(DEPTH + 1);

    logic [PW-1:0] pending_d;

    always_comb begin
        pending_d = pending_q;
        if (done && pending_d != '0) begin
            pending_d = pending_d - PW'(1);
        end
        // A request arriving while full is dropped unless a refresh completes in the
        // same cycle; the priority refresh already pending covers that interval.
        if (tick && pending_d != PW'(DEPTH)) begin
            pending_d = pending_d + PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q  <= '0;
            req_q      <= 1'b0;
            priority_q <= 1'b0;
        end else begin
            pending_q  <= pending_d;
            req_q      <= pending_d != '0;
            if (queue_en) begin
                priority_q <= pending_d == PW'(DEPTH);
            end else begin
                priority_q <= pending_d != '0;
            end
        end
    end

endmodule // refresh_queue

`default_nettype wire

//--- hdl/refresh_timer.sv
// Refresh request timer counting host clocks up to a selected interval.
`default_nettype none

module refresh_timer #(
    parameter int CNT_W = 12
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] interval,
    output logic                  tick_q
);

    logic [CNT_W-1:0] count_q;

    // A restart or a stopped timer holds the count at zero so the next
    // interval is measured from the first enabled clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end else if (restart || !run) begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end else if (count_q >= interval - CNT_W'(1)) begin
            count_q <= '0;
            tick_q  <= 1'b1;
        end else begin
            count_q <= count_q + CNT_W'(1);
            tick_q  <= 1'b0;
        end
    end

endmodule // refresh_timer

`default_nettype wire

//--- testbench/dram_row_type_refresh_control_bench.sv
// Self-checking bench for the DRAM row type and refresh control block.
`default_nettype none

module dram_row_type_refresh_control_bench;
    import dram_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cycle_req, cycle_go, cycle_row_empty, edo_detect_mode, done_en;
    logic        refresh_done, refresh_req, refresh_priority, refresh_type_sel;
    logic        pci_dram_pipeline_en, write_combine_en, read_around_write_en;
    logic        low_addr_drive_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, delay;
    logic [2:0]  cycle_row, precharge_clks;
    logic [1:0]  cycle_type;
    logic [7:0]  row_populated;
    int          error_cnt, num_checks;

    dram_row_type_refresh_control #(.NORMAL_CLKS_60(40), .NORMAL_CLKS_66(50))
        dram_row_type_refresh_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_req(cycle_req), .cycle_row(cycle_row),
        .cycle_go(cycle_go), .cycle_type(cycle_type), .cycle_row_empty(cycle_row_empty),
        .row_populated(row_populated), .precharge_clks(precharge_clks),
        .edo_detect_mode(edo_detect_mode), .refresh_done(refresh_done),
        .refresh_req(refresh_req), .refresh_priority(refresh_priority),
        .refresh_type_sel(refresh_type_sel), .pci_dram_pipeline_en(pci_dram_pipeline_en),
        .write_combine_en(write_combine_en), .read_around_write_en(read_around_write_en),
        .low_addr_drive_sel(low_addr_drive_sel));

    dram_seq_model dram_seq_model_i (.*);

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // The request holds until pready is seen high; release follows that edge.
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx, 2'b00}; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(negedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        if (n >= 16) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, idx, {24'h0, d}, 4'b0001, rd, er);
    endtask

    task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] exp,
                          input logic exp_er);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, idx, 32'h0, 4'b0000, rd, er);
        chk(nm, exp, rd);
        chk("pslverr", {31'h0, exp_er}, {31'h0, er});
    endtask

    task automatic measure(input string nm, input int lo, input int hi);
        int n;
        n = 0;
        while (refresh_req !== 1'b1 && n < 200) begin @(negedge pclk); n++; end
        chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
    endtask

    task automatic drain(input logic [3:0] dly);
        wr(IDX_DRAM_CTRL, 8'h00);
        delay <= dly; done_en <= 1'b1;
        repeat (80) @(posedge pclk);
        chk("drained", 32'h0, {31'h0, refresh_req});
        done_en <= 1'b0;
    endtask

    task automatic t_reset_values;
        rd_chk("bridge_config", IDX_BRIDGE_CFG, 32'h0000_0001, 1'b0);
        rd_chk("buffer_control", IDX_BUFFER_CTRL, 32'h0000_0000, 1'b0);
        rd_chk("auxiliary_control", IDX_AUX_CTRL, 32'h0000_0000, 1'b0);
        rd_chk("dram_row_type", IDX_ROW_TYPE, 32'h0000_0000, 1'b0);
        rd_chk("dram_control", IDX_DRAM_CTRL, 32'h0000_0001, 1'b0);
        chk("precharge_rst", 32'h3, {29'h0, precharge_clks});
    endtask

    task automatic t_reg_rw;
        wr(IDX_BUFFER_CTRL, 8'hFF);
        wr(IDX_AUX_CTRL, 8'hFF);
        rd_chk("buffer_rw", IDX_BUFFER_CTRL, 32'h0000_0007, 1'b0);
        rd_chk("aux_rw", IDX_AUX_CTRL, 32'h0000_0082, 1'b0);
        chk("options", 32'h7, {pci_dram_pipeline_en, write_combine_en, read_around_write_en});
        chk("precharge_long", 32'h4, {29'h0, precharge_clks});
        chk("low_addr", 32'h1, {31'h0, low_addr_drive_sel});
        wr(IDX_BUFFER_CTRL, 8'h02);
        wr(IDX_AUX_CTRL, 8'h00);
        rd_chk("unmapped", 10'h0FC, 32'h0000_0000, 1'b1);
        chk("options_one", 32'h2, {pci_dram_pipeline_en, write_combine_en, read_around_write_en});
        chk("precharge_short", 32'h3, {29'h0, precharge_clks});
    endtask

    task automatic t_row_types;
        logic [15:0] rt;
        rt = 16'h1BE4;
        wr(IDX_ROW_TYPE, rt[7:0]);
        wr(IDX_ROW_TYPE_HI, rt[15:8]);
        rd_chk("row_type_word", IDX_ROW_TYPE, {16'h0, rt}, 1'b0);
        for (int r = 0; r < ROWS; r++) begin
            @(posedge pclk);
            cycle_req <= 1'b1; cycle_row <= r[2:0];
            @(posedge pclk);
            cycle_req <= 1'b0;
            @(negedge pclk);
            chk("cycle_go", 32'h1, {31'h0, cycle_go});
            chk("cycle_type", {30'h0, rt[2*r +: 2]}, {30'h0, cycle_type});
            chk("row_empty", {31'h0, rt[2*r +: 2] == 2'b11}, {31'h0, cycle_row_empty});
        end
        chk("row_populated", 32'hE7, {24'h0, row_populated});
    endtask

    task automatic t_dram_bits;
        wr(IDX_DRAM_CTRL, 8'h30);
        chk("edo_detect", 32'h1, {31'h0, edo_detect_mode});
        chk("ras_only", 32'h1, {31'h0, refresh_type_sel});
        wr(IDX_DRAM_CTRL, 8'h00);
        chk("edo_detect_off", 32'h0, {31'h0, edo_detect_mode});
        chk("cbr", 32'h0, {31'h0, refresh_type_sel});
    endtask

    task automatic t_rates;
        drain(4'd1);
        wr(IDX_DRAM_CTRL, 8'h07);
        measure("fast_interval", 32, 34);
        drain(4'd1);
        wr(IDX_DRAM_CTRL, 8'h07);
        repeat (20) @(posedge pclk);
        wr(IDX_DRAM_CTRL, 8'h01);
        measure("normal_60", 40, 42);
        drain(4'd9);
        wr(IDX_BRIDGE_CFG, 8'h02);
        wr(IDX_DRAM_CTRL, 8'h01);
        measure("normal_66", 50, 52);
        drain(4'd1);
        wr(IDX_DRAM_CTRL, 8'h02);
        repeat (100) @(posedge pclk);
        chk("disabled", 32'h0, {31'h0, refresh_req});
    endtask

    task automatic t_queue;
        wr(IDX_DRAM_CTRL, 8'h47);
        repeat (110) @(posedge pclk);
        chk("queued_req", 32'h1, {31'h0, refresh_req});
        chk("queued_low", 32'h0, {31'h0, refresh_priority});
        repeat (25) @(posedge pclk);
        chk("queued_full", 32'h1, {31'h0, refresh_priority});
        drain(4'd3);
        wr(IDX_DRAM_CTRL, 8'h07);
        repeat (40) @(posedge pclk);
        chk("unqueued_prio", 32'h1, {31'h0, refresh_priority});
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #400us;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        error_cnt = 0; num_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; cycle_req = 1'b0;
        cycle_row = 3'h0; done_en = 1'b0; delay = 4'h1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_reg_rw();
        t_row_types();
        t_dram_bits();
        t_rates();
        t_queue();
        tally_and_finish();
    end
endmodule // dram_row_type_refresh_control_bench

bind dram_row_type_refresh_control dram_row_type_refresh_control_monitor monitor_i (.*);

`default_nettype wire

//--- testbench/dram_row_type_refresh_control_monitor.sv
// Concurrent checks on the ports of the DRAM row type and refresh control block.
`default_nettype none

module dram_row_type_refresh_control_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       cycle_req,
    input wire logic [2:0] cycle_row,
    input wire logic       cycle_go,
    input wire logic [1:0] cycle_type,
    input wire logic       cycle_row_empty,
    input wire logic [7:0] row_populated,
    input wire logic [2:0] precharge_clks,
    input wire logic       refresh_done,
    input wire logic       refresh_req,
    input wire logic       refresh_priority
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pready_after_setup; (psel && !penable) |=> pready; endproperty
    a_pready_after_setup: assert property (p_pready_after_setup)
        else $error("no pready");
    property p_slverr_with_ready; pslverr |-> pready && psel && penable; endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready)
        else $error("stray pslverr");
    property p_go_after_req; cycle_req |=> cycle_go; endproperty
    a_go_after_req: assert property (p_go_after_req)
        else $error("cycle_go late");
    property p_go_has_cause; cycle_go |-> $past(cycle_req); endproperty
    a_go_has_cause: assert property (p_go_has_cause)
        else $error("stray cycle_go");
    property p_empty_decode; cycle_go |-> (cycle_row_empty == (cycle_type == 2'b11)); endproperty
    a_empty_decode: assert property (p_empty_decode)
        else $error("empty flag wrong");
    property p_populated_match;
        cycle_go |-> (row_populated[$past(cycle_row)] == !cycle_row_empty);
    endproperty
    a_populated_match: assert property (p_populated_match)
        else $error("populated map wrong");
    property p_precharge_legal; precharge_clks == 3'd3 || precharge_clks == 3'd4; endproperty
    a_precharge_legal: assert property (p_precharge_legal)
        else $error("bad precharge");
    property p_priority_needs_req; refresh_priority |-> refresh_req; endproperty
    a_priority_needs_req: assert property (p_priority_needs_req)
        else $error("stray priority");
    property p_req_fall_cause; $fell(refresh_req) |-> $past(refresh_done); endproperty
    a_req_fall_cause: assert property (p_req_fall_cause)
        else $error("stray req fall");
endmodule // dram_row_type_refresh_control_monitor

`default_nettype wire

//--- testbench/dram_seq_model.sv
// Behavioural DRAM sequencer that completes pending refreshes after a set delay.
`default_nettype none

module dram_seq_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       refresh_req,
    input  wire logic       done_en,
    input  wire logic [3:0] delay,
    output logic            refresh_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q;

    // Restart after each completion so the request level settles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q        <= 4'h0;
            refresh_done <= 1'b0;
        end else begin
            refresh_done <= 1'b0;
            if (refresh_done || !refresh_req || !done_en) begin
                cnt_q <= 4'h0;
            end else if (cnt_q == delay) begin
                refresh_done <= 1'b1;
                cnt_q        <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // dram_seq_model

`default_nettype wire
